// [logic/busy_timer.sv]
module busy_timer #(
  parameter int CYCLES = eeprom_pkg::WRITE_CYCLE_CLKS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);
  localparam logic [CW-1:0] ONE = CW'(1);
  localparam logic [CW-1:0] ZERO = CW'(0);

  logic [CW-1:0] count_ff;
  logic [CW-1:0] nxt_count;

  always_comb begin
    nxt_count = count_ff;
    if (count_ff != ZERO) begin
      nxt_count = count_ff - ONE;
    end
    // A start while running is refused upstream
    if (start_i && count_ff == ZERO) begin
      nxt_count = LOAD;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_ff <= ZERO;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign busy_o = (count_ff != ZERO);
  assign done_o = (count_ff == ONE);

  busy_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (start_i && !busy_o) |=> busy_o [*3])
    else $error("write cycle ended too early");
endmodule

// [logic/eeprom_spi_engine.sv]
module eeprom_spi_engine #(
  parameter int ADDR_W = eeprom_pkg::ADDR_BITS,
  parameter int PAGE_BYTES = eeprom_pkg::PAGE_SIZE,
  parameter int WRITE_CLKS = eeprom_pkg::WRITE_CYCLE_CLKS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial link
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic hold_n_i,
  input wire logic wp_n_i,
  output logic so_o,
  output logic so_oe_o
);
  localparam int PAGE_W = $clog2(PAGE_BYTES);

  logic [7:0] mem [2**ADDR_W];
  logic [7:0] page_buf [PAGE_BYTES];

  eeprom_pkg::phase_t phase_ff, nxt_phase;
  logic sck_ff, cs_n_ff;
  logic [2:0] bit_cnt_ff, nxt_bit_cnt;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] out_ff, nxt_out;
  logic [7:0] cmd_ff, nxt_cmd;
  logic [7:0] flags_byte_ff, nxt_flags_byte;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [PAGE_BYTES-1:0] mask_ff, nxt_mask;
  logic byte_seen_ff, nxt_byte_seen;
  logic so_ff, nxt_so;
  logic wel_ff, nxt_wel;
  logic protect_pin_enable_ff, nxt_protect_pin_enable;
  logic [1:0] guard_ff, nxt_guard;

  logic live, sck_rise, sck_fall, cs_rise, byte_done, at_boundary;
  logic busy, write_done, hw_locked;
  logic commit_write, commit_flags, set_wel, clr_wel;
  logic [7:0] in_byte, flags_view;

  function automatic logic guarded(input logic [ADDR_W-1:0] a, input logic [1:0] g);
    logic hit;
    unique case (g)
      eeprom_pkg::GUARD_NONE: hit = 1'b0;
      eeprom_pkg::GUARD_QUARTER: hit = (a >= eeprom_pkg::GUARD_QUARTER_BASE);
      eeprom_pkg::GUARD_HALF: hit = (a >= eeprom_pkg::GUARD_HALF_BASE);
      eeprom_pkg::GUARD_ALL: hit = 1'b1;
    endcase
    return hit;
  endfunction

  // Pause gates every sck edge so the bit position freezes
  assign live = ~cs_n_i & hold_n_i;
  assign sck_rise = live & sck_i & ~sck_ff;
  assign sck_fall = live & ~sck_i & sck_ff;
  assign cs_rise = cs_n_i & ~cs_n_ff;
  assign in_byte = {shift_ff[6:0], si_i};
  assign byte_done = sck_rise & (bit_cnt_ff == eeprom_pkg::BIT_LAST);
  assign at_boundary = (bit_cnt_ff == eeprom_pkg::BIT_FIRST) & byte_seen_ff;
  assign hw_locked = protect_pin_enable_ff & ~wp_n_i;

  always_comb begin
    flags_view = eeprom_pkg::BYTE_RESET;
    flags_view[eeprom_pkg::PROTECT_PIN_ENABLE_POS] = protect_pin_enable_ff;
    flags_view[eeprom_pkg::BLOCK_GUARD_BIT1_POS] = guard_ff[1];
    flags_view[eeprom_pkg::BLOCK_GUARD_BIT0_POS] = guard_ff[0];
    flags_view[eeprom_pkg::WRITE_LATCH_FLAG_POS] = wel_ff;
    flags_view[eeprom_pkg::WRITE_BUSY_FLAG_POS] = busy;
  end

  // Commits happen only on a select rise at an exact byte boundary
  assign commit_write = cs_rise & (phase_ff == eeprom_pkg::PH_WR_DATA) & at_boundary
                        & wel_ff & ~busy;
  assign commit_flags = cs_rise & (phase_ff == eeprom_pkg::PH_FLAGS_WR) & at_boundary
                        & wel_ff & ~busy & ~hw_locked;
  assign set_wel = cs_rise & (phase_ff == eeprom_pkg::PH_WAIT) & ~byte_seen_ff & ~busy
                   & (bit_cnt_ff == eeprom_pkg::BIT_FIRST)
                   & (cmd_ff == eeprom_pkg::ENABLE_WRITES_CMD);
  assign clr_wel = cs_rise & (phase_ff == eeprom_pkg::PH_WAIT) & ~byte_seen_ff & ~busy
                   & (bit_cnt_ff == eeprom_pkg::BIT_FIRST)
                   & (cmd_ff == eeprom_pkg::DISABLE_WRITES_CMD);

  busy_timer #(
    .CYCLES(WRITE_CLKS)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(commit_write | commit_flags),
    .busy_o(busy),
    .done_o(write_done)
  );

  // Serial sequencer
  always_comb begin
    nxt_phase = phase_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    nxt_out = out_ff;
    nxt_cmd = cmd_ff;
    nxt_flags_byte = flags_byte_ff;
    nxt_addr = addr_ff;
    nxt_mask = mask_ff;
    nxt_byte_seen = byte_seen_ff;
    nxt_so = so_ff;
    if (cs_n_i) begin
      nxt_phase = eeprom_pkg::PH_OPCODE;
      nxt_bit_cnt = eeprom_pkg::BIT_FIRST;
      nxt_byte_seen = 1'b0;
    end else begin
      if (sck_rise) begin
        nxt_shift = in_byte;
        nxt_bit_cnt = bit_cnt_ff + 3'h1;
      end
      if (byte_done) begin
        unique case (phase_ff)
          eeprom_pkg::PH_OPCODE: begin
            nxt_cmd = in_byte;
            nxt_byte_seen = 1'b0;
            unique case (in_byte)
              eeprom_pkg::CMD_READ, eeprom_pkg::CMD_WRITE: begin
                nxt_phase = eeprom_pkg::PH_ADDR_HI;
              end
              eeprom_pkg::READ_FLAGS_CMD: begin
                nxt_phase = eeprom_pkg::PH_FLAGS_RD;
                nxt_out = flags_view;
              end
              eeprom_pkg::WRITE_FLAGS_CMD: begin
                nxt_phase = eeprom_pkg::PH_FLAGS_WR;
              end
              default: begin
                nxt_phase = eeprom_pkg::PH_WAIT;
              end
            endcase
          end
          eeprom_pkg::PH_ADDR_HI: begin
            nxt_addr[ADDR_W-1:8] = in_byte[ADDR_W-9:0];
            nxt_phase = eeprom_pkg::PH_ADDR_LO;
          end
          eeprom_pkg::PH_ADDR_LO: begin
            nxt_addr[7:0] = in_byte;
            if (cmd_ff == eeprom_pkg::CMD_WRITE) begin
              nxt_phase = eeprom_pkg::PH_WR_DATA;
              nxt_mask = '0;
            end else if (busy) begin
              nxt_phase = eeprom_pkg::PH_WAIT;
            end else begin
              nxt_phase = eeprom_pkg::PH_RD_DATA;
              nxt_out = mem[{addr_ff[ADDR_W-1:8], in_byte}];
            end
          end
          eeprom_pkg::PH_RD_DATA: begin
            nxt_addr = addr_ff + ADDR_W'(1);
            nxt_out = mem[addr_ff + ADDR_W'(1)];
          end
          eeprom_pkg::PH_WR_DATA: begin
            nxt_mask[addr_ff[PAGE_W-1:0]] = 1'b1;
            nxt_addr[PAGE_W-1:0] = addr_ff[PAGE_W-1:0] + PAGE_W'(1);
            nxt_byte_seen = 1'b1;
          end
          eeprom_pkg::PH_FLAGS_RD: begin
            nxt_out = flags_view;
          end
          eeprom_pkg::PH_FLAGS_WR: begin
            nxt_flags_byte = in_byte;
            nxt_byte_seen = 1'b1;
          end
          eeprom_pkg::PH_WAIT: begin
            nxt_byte_seen = 1'b1;
          end
        endcase
      end
      // Output shifts on the fall so the host samples on the next rise
      if (sck_fall && (phase_ff == eeprom_pkg::PH_RD_DATA ||
                       phase_ff == eeprom_pkg::PH_FLAGS_RD)) begin
        nxt_so = out_ff[7];
        nxt_out = {out_ff[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_ff <= eeprom_pkg::PH_OPCODE;
      sck_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      bit_cnt_ff <= eeprom_pkg::BIT_FIRST;
      shift_ff <= eeprom_pkg::BYTE_RESET;
      out_ff <= eeprom_pkg::BYTE_RESET;
      cmd_ff <= eeprom_pkg::BYTE_RESET;
      flags_byte_ff <= eeprom_pkg::BYTE_RESET;
      addr_ff <= '0;
      mask_ff <= '0;
      byte_seen_ff <= 1'b0;
      so_ff <= eeprom_pkg::SO_RESET;
    end else begin
      phase_ff <= nxt_phase;
      sck_ff <= sck_i;
      cs_n_ff <= cs_n_i;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      out_ff <= nxt_out;
      cmd_ff <= nxt_cmd;
      flags_byte_ff <= nxt_flags_byte;
      addr_ff <= nxt_addr;
      mask_ff <= nxt_mask;
      byte_seen_ff <= nxt_byte_seen;
      so_ff <= nxt_so;
    end
  end

  // Latch and flag bits
  always_comb begin
    nxt_wel = wel_ff;
    nxt_protect_pin_enable = protect_pin_enable_ff;
    nxt_guard = guard_ff;
    if (write_done || commit_write || commit_flags || clr_wel) begin
      nxt_wel = 1'b0;
    end
    if (set_wel) begin
      nxt_wel = 1'b1;
    end
    if (commit_flags) begin
      nxt_protect_pin_enable = flags_byte_ff[eeprom_pkg::PROTECT_PIN_ENABLE_POS];
      nxt_guard = {flags_byte_ff[eeprom_pkg::BLOCK_GUARD_BIT1_POS],
                   flags_byte_ff[eeprom_pkg::BLOCK_GUARD_BIT0_POS]};
    end
  end

  // Guard bits stand in for nonvolatile cells and restart at their reset value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wel_ff <= eeprom_pkg::WRITE_LATCH_RESET;
      protect_pin_enable_ff <= eeprom_pkg::PROTECT_PIN_ENABLE_RESET;
      guard_ff <= eeprom_pkg::BLOCK_GUARD_RESET;
    end else begin
      wel_ff <= nxt_wel;
      protect_pin_enable_ff <= nxt_protect_pin_enable;
      guard_ff <= nxt_guard;
    end
  end

  // Page buffer and array; received bytes of the page not guarded land at the start of the busy time
  always_ff @(posedge clk_i) begin
    if (byte_done && phase_ff == eeprom_pkg::PH_WR_DATA) begin
      page_buf[addr_ff[PAGE_W-1:0]] <= in_byte;
    end
    if (commit_write) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (mask_ff[i] && !guarded({addr_ff[ADDR_W-1:PAGE_W], PAGE_W'(i)}, guard_ff)) begin
          mem[{addr_ff[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= page_buf[i];
        end
      end
    end
  end

  assign so_o = so_ff;
  assign so_oe_o = live & (phase_ff == eeprom_pkg::PH_RD_DATA ||
                           phase_ff == eeprom_pkg::PH_FLAGS_RD);

  sequence wr_commit_s;
    cs_rise && phase_ff == eeprom_pkg::PH_WR_DATA && at_boundary && wel_ff && !busy;
  endsequence

  sequence refused_rd_s;
    byte_done && phase_ff == eeprom_pkg::PH_ADDR_LO && cmd_ff != eeprom_pkg::CMD_WRITE && busy;
  endsequence

  opc_shift_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sck_rise |=> shift_ff[0] == $past(si_i) && shift_ff[7:1] == $past(shift_ff[6:0]))
    else $error("serial bit not shifted in");
  wr_commit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_commit_s |=> !wel_ff && busy)
    else $error("page commit did not start write");
  wr_cancel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cs_rise && phase_ff == eeprom_pkg::PH_WR_DATA && bit_cnt_ff != 3'h0 && !busy)
    |=> !busy)
    else $error("misaligned write started");
  refuse_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
    refused_rd_s |=> phase_ff == eeprom_pkg::PH_WAIT ##1 !so_oe_o)
    else $error("array read served while busy");
  wel_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    set_wel |=> wel_ff && flags_view[eeprom_pkg::WRITE_LATCH_FLAG_POS])
    else $error("enable did not set latch");
  wel_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (write_done && !set_wel) |=> !wel_ff)
    else $error("latch kept after write cycle");
  rd_advance_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (byte_done && phase_ff == eeprom_pkg::PH_RD_DATA) |=> addr_ff == $past(addr_ff) + 1'b1)
    else $error("read pointer did not advance");
  page_stay_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (byte_done && phase_ff == eeprom_pkg::PH_WR_DATA)
    |=> addr_ff[ADDR_W-1:PAGE_W] == $past(addr_ff[ADDR_W-1:PAGE_W]))
    else $error("page write left its page");
  hold_float_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !hold_n_i |-> !so_oe_o ##1 (cs_n_ff || ($stable(bit_cnt_ff) && $stable(phase_ff))))
    else $error("output driven or bit position moved during pause");
  so_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(so_ff) |-> $past(sck_fall))
    else $error("output changed without clock fall");
  flags_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (cs_rise && hw_locked) |=> $stable(guard_ff) && $stable(protect_pin_enable_ff))
    else $error("locked flags were written");
  sel_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cs_n_i |=> phase_ff == eeprom_pkg::PH_OPCODE && bit_cnt_ff == 3'h0 && !so_oe_o)
    else $error("select rise did not restart decoder");
endmodule

// [pkg/eeprom_pkg.sv]
package eeprom_pkg;

  // Instruction opcodes
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] DISABLE_WRITES_CMD = 8'h04;
  localparam logic [7:0] ENABLE_WRITES_CMD = 8'h06;
  localparam logic [7:0] READ_FLAGS_CMD = 8'h05;
  localparam logic [7:0] WRITE_FLAGS_CMD = 8'h01;

  // Flag byte layout
  localparam int PROTECT_PIN_ENABLE_POS = 7;
  localparam int BLOCK_GUARD_BIT1_POS = 3;
  localparam int BLOCK_GUARD_BIT0_POS = 2;
  localparam int WRITE_LATCH_FLAG_POS = 1;
  localparam int WRITE_BUSY_FLAG_POS = 0;

  // Values after reset
  localparam logic WRITE_LATCH_RESET = 1'b0;
  localparam logic PROTECT_PIN_ENABLE_RESET = 1'b0;
  localparam logic [1:0] BLOCK_GUARD_RESET = 2'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic SO_RESET = 1'b0;

  // Block guard encodings and range bases
  localparam logic [1:0] GUARD_NONE = 2'h0;
  localparam logic [1:0] GUARD_QUARTER = 2'h1;
  localparam logic [1:0] GUARD_HALF = 2'h2;
  localparam logic [1:0] GUARD_ALL = 2'h3;
  localparam logic [11:0] GUARD_QUARTER_BASE = 12'hC00;
  localparam logic [11:0] GUARD_HALF_BASE = 12'h800;

  // Serial framing
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int ADDR_BITS = 12;
  localparam int PAGE_SIZE = 32;

  // Internal write cycle, longest time rounded down to clocks
  localparam int WRITE_CYCLE_MS = 5;
  localparam int CLK_PERIOD_NS = 40;
  localparam int WRITE_CYCLE_CLKS = WRITE_CYCLE_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    PH_OPCODE = 3'b000,
    PH_ADDR_HI = 3'b001,
    PH_ADDR_LO = 3'b011,
    PH_RD_DATA = 3'b010,
    PH_WR_DATA = 3'b110,
    PH_FLAGS_RD = 3'b111,
    PH_FLAGS_WR = 3'b101,
    PH_WAIT = 3'b100
  } phase_t;

endpackage

// [sim/spi_host.sv]
module spi_host (
  // Clock
  input wire logic clk_i,
  // Serial link
  input wire logic so_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o,
  output logic hold_n_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
    hold_n_o = 1'b1;
  end

  // Idle data line toggles so a stale bit never looks valid
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_i);
      si_o <= ~si_o;
    end
  endtask

  // Select low for the frame; the pause line is left as it stands
  task automatic open_frame();
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    @(posedge clk_i);
  endtask

  // Select rise right after the last bit ends or commits a frame
  task automatic close_frame();
    sck_o <= 1'b0;
    @(posedge clk_i);
    cs_n_o <= 1'b1;
    idle(3);
  endtask

  // Sck low and high three samples each; output sampled late in the low phase
  task automatic bit_io(input logic b, output logic rb);
    sck_o <= 1'b0;
    si_o <= b;
    repeat (3) @(posedge clk_i);
    rb = so_i;
    sck_o <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask

  // Most significant bit first
  task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
  endtask

  // Pause entered with sck low; toggles meanwhile must be ignored
  task automatic pause_on();
    sck_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    hold_n_o <= 1'b0;
    repeat (4) begin
      @(posedge clk_i);
      sck_o <= ~sck_o;
      si_o <= ~si_o;
    end
    @(posedge clk_i);
  endtask

  task automatic pause_off();
    hold_n_o <= 1'b1;
  endtask
endmodule

// [sim/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  // Short write cycle keeps the run brief
  localparam int WCLKS = 400;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wp_n_i = 1'b1;
  logic cs_n;
  logic sck;
  logic si;
  logic hold_n;
  logic so;
  logic so_oe;
  logic so_w;
  logic pen = 1'b0;
  logic [1:0] guard = 2'h0;
  logic [7:0] rx;
  logic [7:0] mem [4096];
  int err_total = 0;
  int compares = 0;
  int seed = 41;
  int cyc = 0;

  always #20 clk_i = ~clk_i;
  // Released output shows the inverse of its last bit
  assign so_w = so_oe ? so : ~so;

  eeprom_spi_engine #(.WRITE_CLKS(WCLKS)) dut (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n),
    .sck_i(sck), .si_i(si), .hold_n_i(hold_n), .wp_n_i(wp_n_i), .so_o(so), .so_oe_o(so_oe));
  spi_host host (.clk_i(clk_i), .so_i(so_w), .cs_n_o(cs_n), .sck_o(sck), .si_o(si),
    .hold_n_o(hold_n));

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      print_verdict();
    end
  end

  function automatic logic prot(input logic [1:0] gv, input logic [11:0] ad);
    return gv == 2'h3 || (gv == 2'h2 && ad >= 12'h800) || (gv == 2'h1 && ad >= 12'hC00);
  endfunction

  function automatic logic [7:0] flags(input logic lat, input logic busy);
    return {pen, 3'h0, guard, lat, busy};
  endfunction

  task automatic cmd(input logic [7:0] op);
    host.open_frame();
    host.xb(op, rx);
    host.close_frame();
  endtask

  task automatic read_flags_cmd(output logic [7:0] f);
    host.open_frame();
    host.xb(eeprom_pkg::READ_FLAGS_CMD, rx);
    host.xb(8'h00, f);
    host.close_frame();
  endtask

  task automatic settle();
    logic [7:0] f;
    repeat (20) begin
      read_flags_cmd(f);
      if (f[0] === 1'b0) break;
    end
    check("idle flags", f, flags(1'b0, 1'b0));
  endtask

  task automatic addr_out(input logic [7:0] op, input logic [11:0] a);
    logic [3:0] junk;
    junk = 4'($random(seed));
    host.open_frame();
    host.xb(op, rx);
    host.xb({junk, a[11:8]}, rx);
    host.xb(a[7:0], rx);
  endtask

  // Random data into one page; then a refused array read while busy and a wait until idle
  task automatic wr(input logic [11:0] a, input int n);
    logic [7:0] d;
    logic [11:0] ad;
    cmd(eeprom_pkg::ENABLE_WRITES_CMD);
    addr_out(eeprom_pkg::CMD_WRITE, a);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      host.xb(d, rx);
      ad = {a[11:5], 5'(a[4:0] + 5'(i))};
      if (!prot(guard, ad)) mem[ad] = d;
    end
    host.close_frame();
    read_flags_cmd(d);
    check("busy flags", d, flags(1'b0, 1'b1));
    addr_out(eeprom_pkg::CMD_READ, a);
    host.xb(8'h00, rx);
    check("busy read oe", {7'h00, so_oe}, 8'h00);
    host.close_frame();
    settle();
  endtask

  task automatic rd(input logic [11:0] a, input int n, input logic brk);
    logic b;
    logic [7:0] d;
    logic [11:0] ad;
    addr_out(eeprom_pkg::CMD_READ, a);
    for (int i = 0; i < n; i++) begin
      for (int j = 7; j >= 0; j--) begin
        if (brk && i == 0 && j == 3) begin
          host.pause_on();
          check("paused oe", {7'h00, so_oe}, 8'h00);
          host.pause_off();
        end
        host.bit_io(1'b0, b);
        d[j] = b;
      end
      ad = a + 12'(i);
      check("read data", d, mem[ad]);
    end
    host.close_frame();
  endtask

  initial begin
    logic [7:0] f;
    logic [11:0] a;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    read_flags_cmd(f);
    check("reset flags", f, 8'h00);
    addr_out(eeprom_pkg::WRITE_FLAGS_CMD, 12'h000);
    host.close_frame();
    read_flags_cmd(f);
    check("flags no latch", f, 8'h00);
    cmd(eeprom_pkg::ENABLE_WRITES_CMD);
    read_flags_cmd(f);
    check("latch set", f, 8'h02);
    cmd(eeprom_pkg::DISABLE_WRITES_CMD);
    read_flags_cmd(f);
    check("latch clear", f, 8'h00);
    host.open_frame();
    host.xb(eeprom_pkg::ENABLE_WRITES_CMD, rx);
    host.xb(eeprom_pkg::CMD_WRITE, rx);
    host.close_frame();
    read_flags_cmd(f);
    check("enable no rise", f, 8'h00);
    for (int k = 0; k < 4; k++) begin
      host.open_frame();
      host.xb(8'($random(seed)) | 8'h08, rx);
      host.xb(8'h00, rx);
      check("unknown oe", {7'h00, so_oe}, 8'h00);
      host.close_frame();
    end
    read_flags_cmd(f);
    check("unknown flags", f, 8'h00);
    wr(12'h000, 2);
    wr(12'hFFE, 2);
    a = 12'($random(seed));
    wr(a, 32);
    rd({a[11:5], 5'h00}, 32, 1'b0);
    a = 12'($random(seed));
    a[4:0] = 5'h1C;
    wr(a, 8);
    rd(a, 4, 1'b1);
    rd({a[11:5], 5'h00}, 4, 1'b0);
    rd(12'hFFE, 4, 1'b0);
    cmd(eeprom_pkg::ENABLE_WRITES_CMD);
    addr_out(eeprom_pkg::CMD_WRITE, 12'h000);
    host.xb(8'h5A, rx);
    repeat (3) host.bit_io(1'b1, f[0]);
    host.close_frame();
    read_flags_cmd(f);
    check("partial cancel", f, 8'h02);
    rd(12'h000, 2, 1'b0);
    for (int gv = 1; gv <= 3; gv++) begin
      cmd(eeprom_pkg::ENABLE_WRITES_CMD);
      host.open_frame();
      host.xb(eeprom_pkg::WRITE_FLAGS_CMD, rx);
      host.xb({4'hF, 2'(gv), 2'h3}, rx);
      host.close_frame();
      pen = 1'b1;
      guard = 2'(gv);
      settle();
      wr(12'h000, 1);
      wr(12'hFFE, 1);
      rd(12'hFFE, 2, 1'b0);
    end
    wp_n_i <= 1'b0;
    cmd(eeprom_pkg::ENABLE_WRITES_CMD);
    addr_out(eeprom_pkg::WRITE_FLAGS_CMD, 12'h000);
    host.close_frame();
    read_flags_cmd(f);
    check("pin locked", f, flags(1'b1, 1'b0));
    wp_n_i <= 1'b1;
    addr_out(eeprom_pkg::WRITE_FLAGS_CMD, 12'h000);
    host.close_frame();
    pen = 1'b0;
    guard = 2'h0;
    settle();
    print_verdict();
  end
endmodule
